/* verilog/phy_ctrl_defs.svh */
/*
 * Offsets, field positions and reset values of the per-port PHY
 * special control and link control registers.
 * Assumes an 8-bit register address and 8-bit register data.
 */
`ifndef PHY_CTRL_DEFS_SVH
`define PHY_CTRL_DEFS_SVH

`define PCD_P1_SPECIAL_OFS    8'h1a
`define PCD_P1_FAULT_LOW_OFS  8'h1b
`define PCD_P1_LINK_CTRL_OFS  8'h1c
`define PCD_P2_SPECIAL_OFS    8'h2a
`define PCD_P2_FAULT_LOW_OFS  8'h2b
`define PCD_P2_LINK_CTRL_OFS  8'h2c
`define PCD_P3_SPECIAL_OFS    8'h3a
`define PCD_P3_FAULT_LOW_OFS  8'h3b
`define PCD_P3_LINK_CTRL_OFS  8'h3c

`define PCD_SP_SHORT_BIT      7
`define PCD_SP_RESULT_HI      6
`define PCD_SP_RESULT_LO      5
`define PCD_SP_TEST_EN_BIT    4
`define PCD_SP_FORCE_LINK_BIT 3
`define PCD_SP_RESERVED_BIT   2
`define PCD_SP_LOOPBACK_BIT   1
`define PCD_SP_COUNT_MSB_BIT  0

`define PCD_LC_AN_EN_BIT      7
`define PCD_LC_SPEED_BIT      6
`define PCD_LC_DUPLEX_BIT     5
`define PCD_LC_ADV_HI         4
`define PCD_LC_ADV_LO         0

`define PCD_RESULT_RST        2'h0
`define PCD_COUNT_RST         9'h000
`define PCD_ADV_RST           5'h1f
`define PCD_FORCE_RST         3'h0
`define PCD_RDATA_RST         8'h00
`define PCD_STRAP_WAIT        2'h3

`endif

/* verilog/phy_ctrl_pkg.sv */
/*
 * Types shared by the PHY port control register bank.
 * Assumes phy_ctrl_defs.svh holds the numeric constants.
 */
package phy_ctrl_pkg;

    typedef enum logic {
        DIAG_IDLE = 1'b0,
        DIAG_RUN  = 1'b1
    } diag_state_t;

    typedef enum logic [1:0] {
        CABLE_NORMAL = 2'h0,
        CABLE_OPEN   = 2'h1,
        CABLE_SHORT  = 2'h2,
        CABLE_FAILED = 2'h3
    } cable_result_t;

    typedef logic [7:0] reg_byte_t;

endpackage : phy_ctrl_pkg

/* verilog/phy_port_control_diag_regs.sv */
/*
 * Per-port PHY special control/status and link control registers for
 * the two copper ports of a three-port switch, index 0 is port 1 and
 * index 1 is port 2.
 * Assumes the register access port, the diagnostic engine and the
 * negotiation engine all run on i_mclk; only the strap pins are
 * asynchronous.
 */
// What this block does
// - A one written to special control bit 4 starts a cable test and the bit clears itself when the test finishes.
// - Bits 6-5 report 00 normal, 01 open, 10 short, 11 failed, and reset to 00.
// - Bit 7 reads one when a short nearer than 10 meters is found, and resets to zero.
// - The 9-bit fault distance has its top bit in special control bit 0 and its low byte in the next register.
// - Port 1 has no low-byte distance register; only port 2 has one.
// - Special control bit 1 loops the port's receive pair back to its own transmit pair at the PMD/PMA layer.
// - Link control bit 7 enables auto-negotiation; when clear, bits 6 and 5 give speed and duplex.
// - With negotiation off, bit 6 selects 100BT when one and 10BT when zero.
// - Bit 5 selects full duplex when one, used when negotiation is off or has failed.
// - Bits 7, 6 and 5 take their reset values from strap pins sampled just after reset is released.
// - Bit 4 resets to one and advertises pause capability; clearing it suppresses it.
// - Bits 3 to 0 reset to one and advertise 100 full, 100 half, 10 full and 10 half.
// - The third port's special, distance and link control locations are reserved and inert.
`include "phy_ctrl_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module phy_port_control_diag_regs (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_b,
    input  wire logic [7:0]                  i_reg_addr,
    input  wire logic                        i_reg_wr,
    input  wire phy_ctrl_pkg::reg_byte_t     i_reg_wdata,
    input  wire logic                        i_port1_led_zero_strap,
    input  wire logic                        i_port1_led_one_strap,
    input  wire logic                        i_mii_rx_valid_strap,
    input  wire logic                        i_mii_rx_bit3_strap,
    input  wire logic                        i_mii_rx_bit2_strap,
    input  wire logic                        i_mii_rx_bit1_strap,
    input  wire logic [1:0]                  i_diag_done,
    input  wire logic [3:0]                  i_diag_result,
    input  wire logic [1:0]                  i_diag_near_short,
    input  wire logic [17:0]                 i_diag_count,
    output phy_ctrl_pkg::reg_byte_t          o_reg_rdata,
    output logic                             o_strap_ready,
    output logic [1:0]                       o_diag_start,
    output logic [1:0]                       o_diag_busy,
    output logic [1:0]                       o_force_link,
    output logic [1:0]                       o_remote_loopback,
    output logic [1:0]                       o_an_enable,
    output logic [1:0]                       o_force_100,
    output logic [1:0]                       o_force_full,
    output logic [9:0]                       o_advertise
);
    import phy_ctrl_pkg::*;

    // Two-flop synchronisers for the six strap pins.
    logic [5:0] strap_meta_reg;
    logic [5:0] strap_sync_reg;
    logic [1:0] strap_wait_reg;
    logic       strap_ready_reg;

    diag_state_t   diag_state_reg  [2];
    cable_result_t result_reg      [2];
    logic [1:0]    near_short_reg;
    logic [8:0]    count_reg       [2];
    logic [1:0]    force_link_reg;
    logic [1:0]    loopback_reg;
    logic [1:0]    start_reg;
    logic [2:0]    force_reg       [2];
    logic [4:0]    adv_reg         [2];
    reg_byte_t     rdata_next;

    logic [1:0] wr_special;
    logic [1:0] wr_link;

    function automatic logic [1:0] port_hit(input logic [7:0] addr,
                                            input logic [7:0] ofs1,
                                            input logic [7:0] ofs2);
        port_hit = {addr == ofs2, addr == ofs1};
    endfunction : port_hit

    // Third-port offsets simply match nothing, so they are inert.
    assign wr_special = i_reg_wr ? port_hit(i_reg_addr, `PCD_P1_SPECIAL_OFS,
                                            `PCD_P2_SPECIAL_OFS) : 2'h0;
    assign wr_link    = i_reg_wr ? port_hit(i_reg_addr, `PCD_P1_LINK_CTRL_OFS,
                                            `PCD_P2_LINK_CTRL_OFS) : 2'h0;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_meta_reg <= 6'h00;
            strap_sync_reg <= 6'h00;
        end else begin
            strap_meta_reg <= {i_mii_rx_bit1_strap, i_mii_rx_bit2_strap,
                               i_mii_rx_bit3_strap, i_mii_rx_valid_strap,
                               i_port1_led_one_strap, i_port1_led_zero_strap};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Straps are caught once the synchroniser has filled after release,
    // since an asynchronous reset may only load constants.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_wait_reg  <= 2'h0;
            strap_ready_reg <= 1'b0;
        end else if (!strap_ready_reg) begin
            strap_wait_reg  <= strap_wait_reg + 2'h1;
            strap_ready_reg <= (strap_wait_reg == `PCD_STRAP_WAIT - 2'h1);
        end
    end

    // Cable test state: a written one starts it, done ends it. A write of
    // zero cannot abort a running test; only completion clears the bit.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int p = 0; p < 2; p++) begin
                diag_state_reg[p] <= DIAG_IDLE;
            end
            start_reg <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                start_reg[p] <= 1'b0;
                if (wr_special[p] && i_reg_wdata[`PCD_SP_TEST_EN_BIT]) begin
                    // A new start in the completion cycle wins.
                    diag_state_reg[p] <= DIAG_RUN;
                    start_reg[p]      <= 1'b1;
                end else if (diag_state_reg[p] == DIAG_RUN
                             && i_diag_done[p]) begin
                    diag_state_reg[p] <= DIAG_IDLE;
                end
            end
        end
    end

    // Results are captured only on completion; register writes never
    // reach them.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int p = 0; p < 2; p++) begin
                result_reg[p] <= CABLE_NORMAL;
                count_reg[p]  <= `PCD_COUNT_RST;
            end
            near_short_reg <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (diag_state_reg[p] == DIAG_RUN && i_diag_done[p]) begin
                    result_reg[p]     <= cable_result_t'(i_diag_result[2*p +: 2]);
                    near_short_reg[p] <= i_diag_near_short[p];
                    count_reg[p]      <= i_diag_count[9*p +: 9];
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            force_link_reg <= 2'h0;
            loopback_reg   <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_special[p]) begin
                    force_link_reg[p] <= i_reg_wdata[`PCD_SP_FORCE_LINK_BIT];
                    loopback_reg[p]   <= i_reg_wdata[`PCD_SP_LOOPBACK_BIT];
                end
            end
        end
    end

    // Link control: bits 7..5 load from the straps once, software writes
    // after that take over.
    // The straps are caught three edges after release rather than during
    // reset, so a board must hold them still until then.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int p = 0; p < 2; p++) begin
                force_reg[p] <= `PCD_FORCE_RST;
                adv_reg[p]   <= `PCD_ADV_RST;
            end
        end else if (!strap_ready_reg) begin
            if (strap_wait_reg == `PCD_STRAP_WAIT - 2'h1) begin
                force_reg[0] <= {strap_sync_reg[0], strap_sync_reg[1],
                                 strap_sync_reg[2]};
                force_reg[1] <= {strap_sync_reg[3], strap_sync_reg[4],
                                 strap_sync_reg[5]};
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_link[p]) begin
                    force_reg[p] <= i_reg_wdata[`PCD_LC_AN_EN_BIT:
                                                `PCD_LC_DUPLEX_BIT];
                    adv_reg[p]   <= i_reg_wdata[`PCD_LC_ADV_HI:
                                                `PCD_LC_ADV_LO];
                end
            end
        end
    end

    function automatic reg_byte_t special_view(input logic        short_f,
                                               input cable_result_t res,
                                               input diag_state_t  st,
                                               input logic        flink,
                                               input logic        loop_f,
                                               input logic        cmsb);
        // Reserved bit 2 always reads zero.
        special_view = {short_f, res, st == DIAG_RUN, flink, 1'b0,
                        loop_f, cmsb};
    endfunction : special_view

    function automatic reg_byte_t link_view(input logic [2:0] mode_f,
                                            input logic [4:0] adv_f);
        link_view = {mode_f, adv_f};
    endfunction : link_view

    always_comb begin
        rdata_next = `PCD_RDATA_RST;
        unique case (i_reg_addr)
            `PCD_P1_SPECIAL_OFS: begin
                rdata_next = special_view(near_short_reg[0], result_reg[0],
                                          diag_state_reg[0],
                                          force_link_reg[0], loopback_reg[0],
                                          count_reg[0][8]);
            end
            `PCD_P2_SPECIAL_OFS: begin
                rdata_next = special_view(near_short_reg[1], result_reg[1],
                                          diag_state_reg[1],
                                          force_link_reg[1], loopback_reg[1],
                                          count_reg[1][8]);
            end
            `PCD_P2_FAULT_LOW_OFS: begin
                rdata_next = count_reg[1][7:0];
            end
            `PCD_P1_LINK_CTRL_OFS: begin
                rdata_next = link_view(force_reg[0], adv_reg[0]);
            end
            `PCD_P2_LINK_CTRL_OFS: begin
                rdata_next = link_view(force_reg[1], adv_reg[1]);
            end
            default: begin
                // Port 1 low byte, third port and unmapped read zero.
                rdata_next = `PCD_RDATA_RST;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= `PCD_RDATA_RST;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

    // Registered control outputs toward the analog front end and the
    // negotiation engine; one cycle behind the register state.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_strap_ready <= 1'b0;
            o_diag_start  <= 2'h0;
            o_diag_busy   <= 2'h0;
        end else begin
            o_strap_ready <= strap_ready_reg;
            o_diag_start  <= start_reg;
            for (int p = 0; p < 2; p++) begin
                o_diag_busy[p] <= (diag_state_reg[p] == DIAG_RUN);
            end
        end
    end

    // Special control outputs toward the analog front end.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_force_link      <= 2'h0;
            o_remote_loopback <= 2'h0;
        end else begin
            o_force_link      <= force_link_reg;
            o_remote_loopback <= loopback_reg;
        end
    end

    // Link control outputs toward the negotiation engine. Speed and duplex
    // pass raw; the engine decides when they apply.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_an_enable  <= 2'h0;
            o_force_100  <= 2'h0;
            o_force_full <= 2'h0;
            o_advertise  <= {`PCD_ADV_RST, `PCD_ADV_RST};
        end else begin
            for (int p = 0; p < 2; p++) begin
                o_an_enable[p]  <= force_reg[p][2];
                o_force_100[p]  <= force_reg[p][1];
                o_force_full[p] <= force_reg[p][0];
            end
            o_advertise <= {adv_reg[1], adv_reg[0]};
        end
    end

endmodule : phy_port_control_diag_regs

`default_nettype wire

/* bench/phy_ctrl_checker.sv */
/*
 * Concurrent checks on the PHY port control register bank.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module phy_ctrl_checker (
    input wire logic                     i_mclk,
    input wire logic                     i_rst_b,
    input wire logic [7:0]               i_reg_addr,
    input wire logic                     i_reg_wr,
    input wire phy_ctrl_pkg::reg_byte_t  i_reg_wdata,
    input wire logic [1:0]               i_diag_done,
    input wire phy_ctrl_pkg::reg_byte_t  o_reg_rdata,
    input wire logic                     o_strap_ready,
    input wire logic [1:0]               o_diag_start,
    input wire logic [1:0]               o_diag_busy,
    input wire logic [1:0]               o_remote_loopback,
    input wire logic [1:0]               o_an_enable,
    input wire logic [1:0]               o_force_100,
    input wire logic [1:0]               o_force_full,
    input wire logic [9:0]               o_advertise
);
    import phy_ctrl_pkg::*;

    default clocking dclk @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_wr1;
        i_reg_wr && i_reg_addr == 8'h1a;
    endsequence
    sequence s_wr2;
        i_reg_wr && i_reg_addr == 8'h2a;
    endsequence
    sequence s_link_wr(a);
        i_reg_wr && i_reg_addr == a && o_strap_ready;
    endsequence

    a_start_pulse: assert property (s_wr2 ##0 i_reg_wdata[4]
        |-> ##[1:2] o_diag_start[1])
        else $error("test start pulse missing");
    a_start_port1: assert property (s_wr1 ##0 i_reg_wdata[4]
        |-> ##[1:2] o_diag_start[0])
        else $error("port one start pulse missing");
    a_busy_sets: assert property (s_wr1 ##0 i_reg_wdata[4]
        |-> ##[1:2] o_diag_busy[0])
        else $error("busy did not rise after start");
    a_done_clears: assert property (o_diag_busy[0] && i_diag_done[0]
        && !i_reg_wr |-> ##[1:2] !o_diag_busy[0])
        else $error("busy did not fall after completion");
    a_unmapped_zero: assert property ((i_reg_addr == 8'h1b
        || i_reg_addr == 8'h3a || i_reg_addr == 8'h3b
        || i_reg_addr == 8'h3c) |=> o_reg_rdata == 8'h00)
        else $error("reserved location read nonzero");
    a_reserved_bit: assert property (i_reg_addr == 8'h2a
        |=> !o_reg_rdata[2])
        else $error("reserved special bit read one");
    a_strap_delay: assert property ($rose(i_rst_b)
        |-> !o_strap_ready ##[2:5] o_strap_ready)
        else $error("strap ready timing wrong");
    a_adv_reset: assert property ($rose(i_rst_b)
        |-> o_advertise == 10'h3ff)
        else $error("advertise bits not one after reset");
    a_loop_set: assert property (s_wr1 ##0 i_reg_wdata[1]
        |-> ##[1:2] o_remote_loopback[0])
        else $error("remote loopback not set");
    a_an_forced: assert property (s_link_wr(8'h2c)
        ##0 i_reg_wdata[7:5] == 3'b100
        |-> ##[1:2] o_an_enable[1] && !o_force_100[1]
            && !o_force_full[1])
        else $error("link mode outputs wrong");
    a_adv_write: assert property (s_link_wr(8'h1c)
        ##0 i_reg_wdata[4:0] == 5'h0a
        |-> ##[1:2] o_advertise[4:0] == 5'h0a)
        else $error("advertise bits not written");

endmodule : phy_ctrl_checker

`default_nettype wire

/* bench/test_phy_port_control_diag_regs.sv */
/*
 * Self-checking bench for the PHY port control register bank.
 * Assumes the design and checker are compiled first; drives at negedge.
 */
`timescale 1ns/100ps
`default_nettype none

module test_phy_port_control_diag_regs;
    import phy_ctrl_pkg::*;

    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;

    logic        i_mclk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    reg_byte_t   i_reg_wdata = 8'h00, o_reg_rdata;
    logic        s_l0 = 1'b0, s_l1 = 1'b0, s_dv = 1'b0;
    logic        s_b3 = 1'b0, s_b2 = 1'b0, s_b1 = 1'b0, o_strap_ready;
    logic [1:0]  i_diag_done = 2'h0, i_diag_near_short = 2'h0;
    logic [3:0]  i_diag_result = 4'h0;
    logic [17:0] i_diag_count = 18'h00000;
    logic [1:0]  o_diag_start, o_diag_busy, o_force_link, o_remote_loopback;
    logic [1:0]  o_an_enable, o_force_100, o_force_full;
    logic [9:0]  o_advertise;
    int          fail_count = 0;
    int          cmp_count = 0;
    // Special control writes keep reserved bit 2 at zero.
    row_t        rows [0:10] = '{
        '{8'h1c, 8'h4a, 8'h4a}, '{8'h2c, 8'h95, 8'h95},
        '{8'h1a, 8'h0a, 8'h0a}, '{8'h1a, 8'he1, 8'h00}, '{8'h2a, 8'he3, 8'h02},
        '{8'h1b, 8'hff, 8'h00}, '{8'h2b, 8'hff, 8'h00}, '{8'h3a, 8'hff, 8'h00},
        '{8'h3b, 8'hff, 8'h00}, '{8'h3c, 8'hff, 8'h00}, '{8'h5a, 8'hff, 8'h00}};

    phy_port_control_diag_regs i_phy_port_control_diag_regs (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .i_port1_led_zero_strap(s_l0), .i_port1_led_one_strap(s_l1),
        .i_mii_rx_valid_strap(s_dv), .i_mii_rx_bit3_strap(s_b3),
        .i_mii_rx_bit2_strap(s_b2), .i_mii_rx_bit1_strap(s_b1),
        .i_diag_done(i_diag_done), .i_diag_result(i_diag_result),
        .i_diag_near_short(i_diag_near_short), .i_diag_count(i_diag_count),
        .o_reg_rdata(o_reg_rdata), .o_strap_ready(o_strap_ready),
        .o_diag_start(o_diag_start), .o_diag_busy(o_diag_busy),
        .o_force_link(o_force_link), .o_remote_loopback(o_remote_loopback),
        .o_an_enable(o_an_enable), .o_force_100(o_force_100),
        .o_force_full(o_force_full), .o_advertise(o_advertise));

    always #50 i_mclk = ~i_mclk;

    task automatic chk(input string n, input logic [9:0] e,
                       input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_mclk);
        i_reg_addr = a;
        @(negedge i_mclk);
        chk($sformatf("reg %h", a), {2'h0, e}, {2'h0, o_reg_rdata});
    endtask : rd

    // Data lines go to the inverse once done drops, so stale capture shows.
    task automatic diag(input int p, input logic [1:0] r, input logic ns,
                        input logic [8:0] c);
        @(negedge i_mclk);
        i_diag_done[p] = 1'b1;
        i_diag_result = {r, r};
        i_diag_near_short = {ns, ns};
        i_diag_count = {c, c};
        @(negedge i_mclk);
        i_diag_done = 2'h0;
        i_diag_result = ~{r, r};
        i_diag_near_short = ~{ns, ns};
        i_diag_count = ~{c, c};
    endtask : diag

    task automatic do_reset(input logic [5:0] s);
        i_rst_b = 1'b0;
        {s_l0, s_l1, s_dv, s_b3, s_b2, s_b1} = s;
        repeat (4) @(negedge i_mclk);
        i_rst_b = 1'b1;
        repeat (5) @(negedge i_mclk);
    endtask : do_reset

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        #(4000 * 100);
        fail_count++;
        close_out();
    end

    initial begin
        do_reset(6'b101011);
        rd(8'h1c, 8'hbf);
        rd(8'h2c, 8'h7f);
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'h00);
        chk("advertise", 10'h3ff, o_advertise);
        $display("test reset values done");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, rows[k].e);
        end
        chk("advertise", 10'h2aa, o_advertise);
        chk("modes", 10'h248, {o_an_enable, o_force_100, o_force_full,
            o_remote_loopback, o_force_link});
        $display("test register rows done");
        wr(8'h2a, 8'h10);
        rd(8'h2a, 8'h10);
        chk("busy", 10'h002, {8'h00, o_diag_busy});
        diag(1, CABLE_SHORT, 1'b1, 9'h155);
        rd(8'h2a, 8'hc1);
        rd(8'h2b, 8'h55);
        chk("busy", 10'h000, {8'h00, o_diag_busy});
        for (int r = 0; r < 4; r++) begin
            wr(8'h1a, 8'h10);
            diag(0, r[1:0], 1'b0, {7'h40, r[1:0]});
            rd(8'h1a, {1'b0, r[1:0], 5'h01});
        end
        diag(0, CABLE_NORMAL, 1'b1, 9'h000);
        rd(8'h1a, 8'h61);
        $display("test cable diagnostic done");
        do_reset(6'b010100);
        rd(8'h1c, 8'h5f);
        rd(8'h2c, 8'h9f);
        rd(8'h2a, 8'h00);
        $display("test second reset done");
        close_out();
    end

endmodule : test_phy_port_control_diag_regs

bind phy_port_control_diag_regs phy_ctrl_checker i_phy_ctrl_checker (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_diag_done(i_diag_done),
    .o_reg_rdata(o_reg_rdata), .o_strap_ready(o_strap_ready),
    .o_diag_start(o_diag_start), .o_diag_busy(o_diag_busy),
    .o_remote_loopback(o_remote_loopback), .o_an_enable(o_an_enable),
    .o_force_100(o_force_100), .o_force_full(o_force_full),
    .o_advertise(o_advertise));

`default_nettype wire
